// file: verilog/csp_defs.svh
// constants for the core status and program flow block
// assumes an 8-bit register port and a 13-bit program counter
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CSP_ADDR_FLAGS2   9'h00D
`define CSP_ADDR_ENABLES2 9'h08D
`define CSP_ADDR_POWER    9'h08E
`define CSP_ADDR_PC_LOW   9'h002
`define CSP_ADDR_STATUS   9'h003
`define CSP_ADDR_POINTER  9'h004
`define CSP_ADDR_LATCH    9'h00A
`define CSP_ADDR_INTCTL   9'h00B
`define CSP_ADDR_INDIRECT 9'h000
`define CSP_ADDR_FLAGS2_HI  9'h08D

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSP_BIT_LOW_VOLT   7
`define CSP_BIT_COLLISION  3
`define CSP_BIT_OSC_SPEED  3
`define CSP_BIT_POR        1
`define CSP_BIT_BROWNOUT   0
`define CSP_BIT_BANK       7
`define CSP_BIT_PERIPH_EN  6
`define CSP_BIT_GLOBAL_EN  7
`define CSP_FLAG_MASK      8'h88
`define CSP_POWER_MASK     8'h0B

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define CSP_RST_BYTE       8'h00
`define CSP_RST_POWER      8'h08
`define CSP_RST_PC         13'h0000
`define CSP_RST_PTR        3'h0
`define CSP_ZERO_9         9'h000
`define CSP_ONE_3          3'h1
`define CSP_ONE_13         13'h0001
`define CSP_PAGE_LO        3
`define CSP_PAGE_HI        4

`endif

// file: verilog/csp_pkg.sv
// types for the core status and program flow block
// assumes csp_defs.svh is on the include path
`default_nettype none
package csp_pkg;
   // program flow operations issued by the instruction decoder
   typedef enum logic [2:0]
   {
      CSP_OP_STEP = 3'h0,
      CSP_OP_JUMP = 3'h1,
      CSP_OP_CALL = 3'h3,
      CSP_OP_RET = 3'h2,
      CSP_OP_IRQ = 3'h6,
      CSP_OP_NONE = 3'h7
   } csp_op_t;
endpackage
`default_nettype wire

// file: verilog/csp_core.sv
// core status and program flow: second interrupt flags and enables,
// power control, program counter with latch, return stack, indirect access
// assumes one core clock, reset causes as pulses from the supervisor,
// and a data memory answering on the same cycle it is addressed
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.svh"

// Behaviour
// - enable bit 7 gates the low-voltage interrupt
// - enable bit 3 gates the bus-collision interrupt
// - unimplemented bits of flags and enables read zero
// - flags set on their event regardless of any enable
// - low-voltage flag sets on supply dip, held until software clears
// - collision flag sets on master collision, held until software clears
// - oscillator speed bit resets to one, selects fast or slow clock
// - power-on bit cleared by power-on reset only, set by software
// - brown-out bit cleared by brown-out reset, undefined when detector off
// - program counter is 13 bits, low byte read and write
// - software writes upper counter bits only through the high latch
// - 8K word program space in 2K pages
// - call and jump take page bits from latch bits 4 and 3
// - stack operations leave latch alone; return restores whole address
// - stack is 8 by 13 bits with hidden pointer
// - push on call or interrupt, pop on any return
// - stack wraps around with no overflow sign
// - indirect access reaches the register named by the pointer
// - indirect access to itself reads zero and writes nothing
// - indirect address is bank bit over the 8-bit pointer
// - peripheral interrupts need the peripheral enable bit
module csp_core
   import csp_pkg::*;
#(
   parameter int PC_W = 13,
   parameter int STACK_DEPTH = 8
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic por_event,
   input wire logic brownout_event,
   input wire logic brownout_detect_en,
   input wire logic low_volt_detect,
   input wire logic collision_event,
   input wire logic [8:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] flow_op,
   input wire logic [10:0] flow_target,
   output logic [PC_W-1:0] fetch_addr,
   output logic periph_irq,
   output logic osc_speed_select,
   output logic [8:0] mem_addr,
   output logic mem_wr,
   output logic mem_rd,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata
);

   // ----------------------------------------
   // reset release and input synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;
   logic [2:0] lv_sync;
   logic [2:0] col_sync;
   logic [2:0] por_sync;
   logic [2:0] bo_sync;
   logic [2:0] boen_sync;
   logic lv_level;
   logic col_level;
   logic por_level;
   logic bo_level;
   logic boen_level;
   logic next_lv_level;
   logic next_col_level;
   logic next_por_level;
   logic next_bo_level;
   logic next_boen_level;

   assign rst_n = rst_sync[1];

   // two-stage reset release
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   // filtered level follows when second and third stage agree
   function automatic logic filt(input logic [2:0] s, input logic cur);
      filt = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   always_comb
   begin
      next_lv_level = filt(lv_sync, lv_level);
      next_col_level = filt(col_sync, col_level);
      next_por_level = filt(por_sync, por_level);
      next_bo_level = filt(bo_sync, bo_level);
      next_boen_level = filt(boen_sync, boen_level);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lv_sync <= 3'h0;
         col_sync <= 3'h0;
         por_sync <= 3'h0;
         bo_sync <= 3'h0;
         boen_sync <= 3'h0;
         lv_level <= 1'b0;
         col_level <= 1'b0;
         por_level <= 1'b0;
         bo_level <= 1'b0;
         boen_level <= 1'b0;
      end
      else
      begin
         lv_sync <= {lv_sync[1:0], low_volt_detect};
         col_sync <= {col_sync[1:0], collision_event};
         por_sync <= {por_sync[1:0], por_event};
         bo_sync <= {bo_sync[1:0], brownout_event};
         boen_sync <= {boen_sync[1:0], brownout_detect_en};
         lv_level <= next_lv_level;
         col_level <= next_col_level;
         por_level <= next_por_level;
         bo_level <= next_bo_level;
         boen_level <= next_boen_level;
      end
   end

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [7:0] flags2;
   logic [7:0] enables2;
   logic [7:0] power;
   logic [7:0] status;
   logic [7:0] file_pointer;
   logic [7:0] pc_high_latch;
   logic [7:0] intctl;
   logic lv_prev;
   logic col_prev;
   logic [7:0] next_flags2;
   logic [7:0] next_enables2;
   logic [7:0] next_power;
   logic [7:0] next_status;
   logic [7:0] next_file_pointer;
   logic [7:0] next_pc_high_latch;
   logic [7:0] next_intctl;
   logic [7:0] next_reg_rdata;
   logic next_periph_irq;
   logic [8:0] eff_addr;
   logic [8:0] ind_addr;
   logic ind_self;
   logic ind_hit;
   logic lv_rise;
   logic col_rise;
   logic [7:0] rd_local;
   logic rd_is_local;

   // register hit on effective address
   function automatic logic hit(input logic [8:0] a, input logic [8:0] r);
      hit = (a == r);
   endfunction

   assign ind_addr = {status[`CSP_BIT_BANK], file_pointer};
   assign ind_hit = hit(reg_addr, `CSP_ADDR_INDIRECT);
   assign ind_self = ind_hit && (file_pointer == `CSP_RST_BYTE);
   assign eff_addr = ind_hit ? ind_addr : reg_addr;
   assign lv_rise = lv_level && !lv_prev;
   assign col_rise = col_level && !col_prev;

   // register writes, event flags and reset causes
   always_comb
   begin
      next_flags2 = flags2;
      next_enables2 = enables2;
      next_power = power;
      next_status = status;
      next_file_pointer = file_pointer;
      next_pc_high_latch = pc_high_latch;
      next_intctl = intctl;
      if (reg_wr && !ind_self)
      begin
         if (hit(eff_addr, `CSP_ADDR_FLAGS2))
            next_flags2 = reg_wdata & `CSP_FLAG_MASK;
         if (hit(eff_addr, `CSP_ADDR_ENABLES2))
            next_enables2 = reg_wdata & `CSP_FLAG_MASK;
         if (hit(eff_addr, `CSP_ADDR_POWER))
            next_power = reg_wdata & `CSP_POWER_MASK;
         if (hit(eff_addr, `CSP_ADDR_STATUS))
            next_status = reg_wdata;
         if (hit(eff_addr, `CSP_ADDR_POINTER))
            next_file_pointer = reg_wdata;
         if (hit(eff_addr, `CSP_ADDR_LATCH))
            next_pc_high_latch = reg_wdata;
         if (hit(eff_addr, `CSP_ADDR_INTCTL))
            next_intctl = reg_wdata;
      end
      // flags set after the write so the event wins
      if (lv_rise)
         next_flags2[`CSP_BIT_LOW_VOLT] = 1'b1;
      if (col_rise)
         next_flags2[`CSP_BIT_COLLISION] = 1'b1;
      if (por_level)
         next_power[`CSP_BIT_POR] = 1'b0;
      if (bo_level && boen_level)
         next_power[`CSP_BIT_BROWNOUT] = 1'b0;
      if (por_level || (bo_level && boen_level))
         next_power[`CSP_BIT_OSC_SPEED] = 1'b1;
      // peripheral sources gated by own enable and the peripheral enable
      next_periph_irq = next_intctl[`CSP_BIT_PERIPH_EN] &&
         ((next_flags2[`CSP_BIT_LOW_VOLT] && next_enables2[`CSP_BIT_LOW_VOLT]) ||
         (next_flags2[`CSP_BIT_COLLISION] && next_enables2[`CSP_BIT_COLLISION]));
   end

   // register file; arst_n also serves as the power-on reset
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags2 <= `CSP_RST_BYTE;
         enables2 <= `CSP_RST_BYTE;
         power <= `CSP_RST_POWER;
         status <= `CSP_RST_BYTE;
         file_pointer <= `CSP_RST_BYTE;
         pc_high_latch <= `CSP_RST_BYTE;
         intctl <= `CSP_RST_BYTE;
         lv_prev <= 1'b0;
         col_prev <= 1'b0;
         periph_irq <= 1'b0;
      end
      else
      begin
         flags2 <= next_flags2;
         enables2 <= next_enables2;
         power <= next_power;
         status <= next_status;
         file_pointer <= next_file_pointer;
         pc_high_latch <= next_pc_high_latch;
         intctl <= next_intctl;
         lv_prev <= lv_level;
         col_prev <= col_level;
         periph_irq <= next_periph_irq;
      end
   end

   // ----------------------------------------
   // program counter and return stack
   // ----------------------------------------
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [$clog2(STACK_DEPTH)-1:0] stack_ptr;
   logic [$clog2(STACK_DEPTH)-1:0] next_stack_ptr;
   logic [$clog2(STACK_DEPTH)-1:0] pop_ptr;
   logic push_en;
   logic pc_low_wr;

   assign pop_ptr = stack_ptr - 3'(`CSP_ONE_3);
   assign pc_low_wr = reg_wr && !ind_self && hit(eff_addr, `CSP_ADDR_PC_LOW);

   // next counter: low byte write loads high bits from latch
   always_comb
   begin
      next_pc = pc + 13'(`CSP_ONE_13);
      next_stack_ptr = stack_ptr;
      push_en = 1'b0;
      case (csp_op_t'(flow_op))
         CSP_OP_STEP:
            next_pc = pc + 13'(`CSP_ONE_13);
         CSP_OP_JUMP:
            next_pc = {pc_high_latch[`CSP_PAGE_HI:`CSP_PAGE_LO], flow_target};
         CSP_OP_CALL:
         begin
            next_pc = {pc_high_latch[`CSP_PAGE_HI:`CSP_PAGE_LO], flow_target};
            push_en = 1'b1;
            next_stack_ptr = stack_ptr + 3'(`CSP_ONE_3);
         end
         CSP_OP_IRQ:
         begin
            next_pc = {2'h0, flow_target};
            push_en = 1'b1;
            next_stack_ptr = stack_ptr + 3'(`CSP_ONE_3);
         end
         CSP_OP_RET:
         begin
            next_pc = stack_mem[pop_ptr];
            next_stack_ptr = pop_ptr;
         end
         CSP_OP_NONE:
            next_pc = pc;
         default:
            next_pc = pc;
      endcase
      if (pc_low_wr)
         next_pc = {pc_high_latch[PC_W-9:0], reg_wdata};
   end

   // counter, stack pointer and stack storage
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc <= `CSP_RST_PC;
         stack_ptr <= `CSP_RST_PTR;
      end
      else
      begin
         pc <= next_pc;
         stack_ptr <= next_stack_ptr;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (push_en)
         stack_mem[stack_ptr] <= pc + 13'(`CSP_ONE_13);
   end

   // ----------------------------------------
   // read path and data memory port
   // ----------------------------------------
   always_comb
   begin
      rd_is_local = 1'b1;
      rd_local = `CSP_RST_BYTE;
      if (ind_self)
         rd_local = `CSP_RST_BYTE;
      else if (hit(eff_addr, `CSP_ADDR_FLAGS2))
         rd_local = flags2;
      else if (hit(eff_addr, `CSP_ADDR_ENABLES2))
         rd_local = enables2;
      else if (hit(eff_addr, `CSP_ADDR_POWER))
         rd_local = power;
      else if (hit(eff_addr, `CSP_ADDR_STATUS))
         rd_local = status;
      else if (hit(eff_addr, `CSP_ADDR_POINTER))
         rd_local = file_pointer;
      else if (hit(eff_addr, `CSP_ADDR_LATCH))
         rd_local = pc_high_latch;
      else if (hit(eff_addr, `CSP_ADDR_INTCTL))
         rd_local = intctl;
      else if (hit(eff_addr, `CSP_ADDR_PC_LOW))
         rd_local = pc[7:0];
      else
         rd_is_local = 1'b0;
      next_reg_rdata = rd_is_local ? rd_local : mem_rdata;
      if (!reg_rd)
         next_reg_rdata = `CSP_RST_BYTE;
   end

   // outputs registered; memory strobes only for non-local addresses
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= `CSP_RST_BYTE;
         fetch_addr <= `CSP_RST_PC;
         osc_speed_select <= 1'b1;
         mem_addr <= `CSP_ZERO_9;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         mem_wdata <= `CSP_RST_BYTE;
      end
      else
      begin
         reg_rdata <= next_reg_rdata;
         fetch_addr <= next_pc;
         osc_speed_select <= next_power[`CSP_BIT_OSC_SPEED];
         mem_addr <= eff_addr;
         mem_wr <= reg_wr && !ind_self && !rd_is_local;
         mem_rd <= reg_rd && !ind_self && !rd_is_local;
         mem_wdata <= reg_wdata;
      end
   end

endmodule
`default_nettype wire

// file: bench/csp_core_props.sv
// assertions on the ports of the core status and program flow block
// assumes csp_defs.svh on the include path; bound to every csp_core
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.svh"
module csp_core_props
   import csp_pkg::*;
#(
   parameter int PC_W = 13,
   parameter int STACK_DEPTH = 8
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic por_event,
   input wire logic brownout_event,
   input wire logic brownout_detect_en,
   input wire logic low_volt_detect,
   input wire logic collision_event,
   input wire logic [8:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] flow_op,
   input wire logic [10:0] flow_target,
   input wire logic [PC_W-1:0] fetch_addr,
   input wire logic periph_irq,
   input wire logic osc_speed_select,
   input wire logic [8:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata
);
   // --------------------------------
   // port relations
   // --------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   // write to power register reaches the speed output on the next cycle
   property p_osc;
      reg_wr && reg_addr == `CSP_ADDR_POWER
      |=> osc_speed_select == $past(reg_wdata[`CSP_BIT_OSC_SPEED]);
   endproperty

   a_flags_unimpl_zero: assert property (
      reg_rd && reg_addr == `CSP_ADDR_FLAGS2 |=> (reg_rdata & 8'h77) == 8'h00)
      else $error("flag register unused bits read nonzero");
   a_enables_unimpl_zero: assert property (
      reg_rd && reg_addr == `CSP_ADDR_ENABLES2 |=> (reg_rdata & 8'h77) == 8'h00)
      else $error("enable register unused bits read nonzero");
   a_power_unimpl_zero: assert property (
      reg_rd && reg_addr == `CSP_ADDR_POWER |=> (reg_rdata & 8'hF4) == 8'h00)
      else $error("power register unused bits read nonzero");
   a_osc_follow_write: assert property (p_osc)
      else $error("speed output does not follow power bit 3");
   a_branch_target: assert property (
      (flow_op == CSP_OP_JUMP || flow_op == CSP_OP_CALL) && !reg_wr
      |=> fetch_addr[10:0] == $past(flow_target))
      else $error("branch target not loaded");
   a_hold_pc_stable: assert property (
      flow_op == CSP_OP_NONE && !reg_wr |=> $stable(fetch_addr))
      else $error("program counter moved while held");
   a_pcl_write_low: assert property (
      reg_wr && reg_addr == `CSP_ADDR_PC_LOW && flow_op == CSP_OP_NONE
      |=> fetch_addr[7:0] == $past(reg_wdata))
      else $error("pc low write not taken");
   a_mem_write_cause: assert property (
      mem_wr |-> $past(reg_wr) && mem_wdata == $past(reg_wdata))
      else $error("memory write without register write");
   a_mem_read_cause: assert property (
      mem_rd |-> $past(reg_rd) && mem_addr != `CSP_ADDR_INDIRECT)
      else $error("memory read without register read");

   // main scenarios
   c_call: cover property (flow_op == CSP_OP_CALL);
   c_mem_write: cover property (mem_wr);
   c_mem_read: cover property (mem_rd);
   c_irq_rise: cover property ($rose(periph_irq));
endmodule

bind csp_core csp_core_props #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) csp_core_props_i (
   .core_clk(core_clk), .arst_n(arst_n), .por_event(por_event),
   .brownout_event(brownout_event), .brownout_detect_en(brownout_detect_en),
   .low_volt_detect(low_volt_detect), .collision_event(collision_event),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .flow_op(flow_op), .flow_target(flow_target),
   .fetch_addr(fetch_addr), .periph_irq(periph_irq), .osc_speed_select(osc_speed_select),
   .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata));
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the core status and program flow block
// assumes the design and its checker are compiled before this file
`timescale 1ns/100ps
`default_nettype none
`include "csp_defs.svh"
module tb;
   import csp_pkg::*;
   logic core_clk = 0;
   logic arst_n = 0;
   logic por_event = 0;
   logic brownout_event = 0;
   logic brownout_detect_en = 1;
   logic low_volt_detect = 0;
   logic collision_event = 0;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic [8:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0;
   logic [7:0] mem_rdata = 0;
   logic [2:0] flow_op = CSP_OP_NONE;
   logic [10:0] flow_target = 0;
   logic [10:0] t;
   logic [7:0] reg_rdata, mem_wdata, rv, mwd, dd, mem_prev;
   logic [12:0] fetch_addr, d;
   logic [12:0] a [10];
   logic [8:0] mem_addr, mwa;
   logic periph_irq, osc_speed_select, mem_wr, mem_rd, mw;
   logic [4:0] lat;
   int miscompares = 0;
   int n_checks = 0;

   csp_core csp_core_i (.core_clk(core_clk), .arst_n(arst_n), .por_event(por_event),
      .brownout_event(brownout_event), .brownout_detect_en(brownout_detect_en),
      .low_volt_detect(low_volt_detect), .collision_event(collision_event),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .flow_op(flow_op), .flow_target(flow_target),
      .fetch_addr(fetch_addr), .periph_irq(periph_irq),
      .osc_speed_select(osc_speed_select), .mem_addr(mem_addr), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // clock and a changing memory answer
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) {mem_prev, mem_rdata} <= {mem_rdata, 8'($urandom)};

   // --------------------------------
   // bench tasks
   // --------------------------------
   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string s);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // register write; captures the memory side one cycle on
   task automatic wr(input logic [8:0] ad, input logic [7:0] dt);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
      mw = mem_wr;
      mwa = mem_addr;
      mwd = mem_wdata;
   endtask

   task automatic rc(input logic [8:0] ad, input logic [7:0] e, input logic [7:0] m,
      input string s);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
      mw = mem_rd;
      mwa = mem_addr;
      chk(rv & m, e, s);
   endtask

   task automatic fl(input csp_op_t o, input logic [10:0] tg);
      @(posedge core_clk);
      flow_op <= o;
      flow_target <= tg;
      @(posedge core_clk);
      flow_op <= CSP_OP_NONE;
      #1;
   endtask

   // event pulse: 0 low volt, 1 collision, 2 brownout, 3 power-on
   task automatic pulse(input int w);
      @(posedge core_clk);
      {por_event, brownout_event, collision_event, low_volt_detect} <= 4'h1 << w;
      repeat (6) @(posedge core_clk);
      {por_event, brownout_event, collision_event, low_volt_detect} <= 4'h0;
      repeat (6) @(posedge core_clk);
      #1;
   endtask

   task automatic wait_irq(input logic e);
      int k;
      k = 0;
      while (periph_irq !== e && k < 20)
      begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk(periph_irq, e, "irq level");
      if (k == 20)
         report_and_stop();
   endtask

   // hang guard
   initial
   begin
      #1000000;
      miscompares++;
      report_and_stop();
   end

   // --------------------------------
   // main sequence
   // --------------------------------
   initial
   begin
      void'($urandom(32'hBA8B));
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rc(`CSP_ADDR_FLAGS2, 8'h00, 8'hFF, "flags reset");
      rc(`CSP_ADDR_ENABLES2, 8'h00, 8'hFF, "enables reset");
      rc(`CSP_ADDR_POWER, 8'h08, 8'hFF, "power reset");
      chk(osc_speed_select, 1'b1, "osc reset");
      wr(`CSP_ADDR_ENABLES2, 8'hFF);
      rc(`CSP_ADDR_ENABLES2, 8'h88, 8'hFF, "enables mask");
      wr(`CSP_ADDR_FLAGS2, 8'hFF);
      rc(`CSP_ADDR_FLAGS2, 8'h88, 8'hFF, "flags mask");
      wr(`CSP_ADDR_FLAGS2, 8'h00);
      wr(`CSP_ADDR_ENABLES2, 8'h08);
      wr(`CSP_ADDR_INTCTL, 8'h40);
      pulse(0);
      rc(`CSP_ADDR_FLAGS2, 8'h80, 8'hFF, "low volt flag");
      chk(periph_irq, 1'b0, "low volt masked");
      wr(`CSP_ADDR_ENABLES2, 8'h80);
      wait_irq(1'b1);
      wr(`CSP_ADDR_INTCTL, 8'h00);
      wait_irq(1'b0);
      wr(`CSP_ADDR_INTCTL, 8'h40);
      wr(`CSP_ADDR_FLAGS2, 8'h00);
      wait_irq(1'b0);
      pulse(1);
      rc(`CSP_ADDR_FLAGS2, 8'h08, 8'hFF, "collision flag");
      chk(periph_irq, 1'b0, "collision masked");
      wr(`CSP_ADDR_ENABLES2, 8'h08);
      wait_irq(1'b1);
      wr(`CSP_ADDR_FLAGS2, 8'h00);
      wait_irq(1'b0);
      $display("test flags done");
      wr(`CSP_ADDR_POWER, 8'hFF);
      rc(`CSP_ADDR_POWER, 8'h0B, 8'hFF, "power mask");
      pulse(2);
      rc(`CSP_ADDR_POWER, 8'h0A, 8'hFF, "brownout cause");
      wr(`CSP_ADDR_POWER, 8'h03);
      rc(`CSP_ADDR_POWER, 8'h03, 8'hFF, "slow clock");
      chk(osc_speed_select, 1'b0, "osc slow");
      pulse(3);
      rc(`CSP_ADDR_POWER, 8'h00, 8'h02, "power-on cause");
      wr(`CSP_ADDR_POWER, 8'h0B);
      rc(`CSP_ADDR_POWER, 8'h0B, 8'hFF, "causes set");
      @(posedge core_clk);
      brownout_detect_en <= 1'b0;
      pulse(2);
      rc(`CSP_ADDR_POWER, 8'h0A, 8'hFE, "detector off");
      @(posedge core_clk);
      brownout_detect_en <= 1'b1;
      $display("test power done");
      for (int i = 0; i < 6; i++)
      begin
         lat = (i == 0) ? 5'h1F : 5'($urandom);
         t = (i == 0) ? 11'h7FF : 11'($urandom);
         dd = 8'($urandom);
         wr(`CSP_ADDR_LATCH, {3'h0, lat});
         fl(CSP_OP_JUMP, t);
         chk(fetch_addr, {lat[4:3], t}, "jump page");
         wr(`CSP_ADDR_PC_LOW, dd);
         chk(fetch_addr, {lat, dd}, "pc low write");
         rc(`CSP_ADDR_PC_LOW, dd, 8'hFF, "pc low read");
         fl(CSP_OP_STEP, t);
         chk(fetch_addr, 13'({lat, dd} + 13'h1), "step");
      end
      $display("test counter done");
      wr(`CSP_ADDR_LATCH, 8'h10);
      for (int i = 0; i < 10; i++)
      begin
         a[i] = fetch_addr;
         fl(CSP_OP_CALL, 11'($urandom));
         chk(fetch_addr[12:11], 2'h2, "call page");
      end
      rc(`CSP_ADDR_LATCH, 8'h10, 8'h1F, "latch after push");
      wr(`CSP_ADDR_LATCH, 8'h00);
      for (int i = 9; i >= 1; i--)
      begin
         fl(CSP_OP_RET, 11'h000);
         if (i == 9)
            d = fetch_addr - a[9];
         chk(d[12:1], 12'h000, "return offset");
         chk(fetch_addr, ((i > 1) ? a[i] : a[9]) + d, "pop order");
      end
      rc(`CSP_ADDR_LATCH, 8'h00, 8'h1F, "latch after pop");
      a[0] = fetch_addr;
      fl(CSP_OP_IRQ, 11'h123);
      chk(fetch_addr, 13'h0123, "irq branch");
      fl(CSP_OP_RET, 11'h000);
      chk(fetch_addr, a[0] + d, "irq return");
      $display("test stack done");
      wr(`CSP_ADDR_STATUS, 8'h80);
      wr(`CSP_ADDR_POINTER, 8'h20);
      dd = 8'($urandom);
      wr(`CSP_ADDR_INDIRECT, dd);
      chk({mw, mwa, mwd}, {1'b1, 9'h120, dd}, "indirect write");
      wr(`CSP_ADDR_STATUS, 8'h00);
      wr(`CSP_ADDR_POINTER, 8'h00);
      wr(`CSP_ADDR_INDIRECT, 8'h5A);
      chk(mw, 1'b0, "self write");
      rc(`CSP_ADDR_INDIRECT, 8'h00, 8'hFF, "self read");
      chk(mw, 1'b0, "self read strobe");
      wr(`CSP_ADDR_POINTER, 8'h0A);
      wr(`CSP_ADDR_INDIRECT, 8'h0D);
      rc(`CSP_ADDR_LATCH, 8'h0D, 8'h1F, "indirect to latch");
      rc(`CSP_ADDR_INDIRECT, 8'h0D, 8'h1F, "indirect read");
      wr(9'h1F0, 8'hC3);
      chk({mw, mwa, mwd}, {1'b1, 9'h1F0, 8'hC3}, "unmapped write");
      rc(9'h1F1, 8'h00, 8'h00, "unmapped read");
      chk({mw, mwa, rv}, {1'b1, 9'h1F1, mem_prev}, "unmapped read data");
      $display("test indirect done");
      report_and_stop();
   end
endmodule
`default_nettype wire
